/* File: rtl/timer16_wave_ctrl.sv */
// Waveform mode and compare-output control of a 16-bit timer.
// Assumes timer_tick_i is a one-cycle enable made on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module timer16_wave_ctrl (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        timer_tick_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic [7:0]  port_dir_i,
    input  wire logic [7:0]  port_data_i,
    output logic      [7:0]  pin_data_o,
    output logic      [7:0]  pin_oe_n_o,
    output logic             chan_a_wave_out_o,
    output logic             chan_b_wave_out_o,
    output logic      [2:0]  flags_o
);

    // Control registers
    logic [7:0]  timer_control_a_r, timer_control_a_nxt;
    logic [7:0]  timer_control_b_r, timer_control_b_nxt;
    logic [7:0]  timer_control_d_r, timer_control_d_nxt;
    logic [15:0] capture_value_r, capture_value_nxt;

    // Counter, flags, outputs
    timer16_pkg::count_s cnt_r, cnt_nxt;
    timer16_pkg::flags_s flags_r, flags_nxt;
    logic        block_r, block_nxt;
    logic        wave_a_r, wave_a_nxt;
    logic        wave_b_r, wave_b_nxt;
    logic [7:0]  pin_data_r, pin_data_nxt;
    logic [7:0]  pin_oe_n_r, pin_oe_n_nxt;
    logic [15:0] rdata_r, rdata_nxt;

    // Decoded state
    logic [3:0]  waveform_mode_select;
    logic        waveform_mode_msb;
    logic [1:0]  chan_a_output_mode, chan_b_output_mode;
    logic [3:0]  chan_a_pin_enable, chan_b_pin_enable;
    timer16_pkg::mode_class_e mode_class;
    logic [15:0] compare_value_a, compare_value_b, buffer_a, buffer_b, top_value;
    logic        at_top, at_bottom, at_max, tick, match_a, match_b;
    logic        load_at_top, load_at_bottom, load_cmp, immediate, ovf_event;
    logic        wr_cmp_a, wr_cmp_b, conn_a, conn_b, is_pwm;

    // Mode selector split over two control registers
    assign waveform_mode_select = {
        timer_control_b_r[timer16_pkg::CTRL_B_WHIGH_HI:timer16_pkg::CTRL_B_WHIGH_LO],
        timer_control_a_r[timer16_pkg::CTRL_A_WLOW_HI:timer16_pkg::CTRL_A_WLOW_LO]
    };
    assign waveform_mode_msb  = waveform_mode_select[3];
    assign chan_a_output_mode =
        timer_control_a_r[timer16_pkg::CTRL_A_MODE_A_HI:timer16_pkg::CTRL_A_MODE_A_LO];
    assign chan_b_output_mode =
        timer_control_a_r[timer16_pkg::CTRL_A_MODE_B_HI:timer16_pkg::CTRL_A_MODE_B_LO];
    assign chan_a_pin_enable  = timer_control_d_r[3:0];
    assign chan_b_pin_enable  = timer_control_d_r[7:4];

    // Mode class of each waveform mode
    always_comb begin
        case (waveform_mode_select)
            4'h0:                mode_class = timer16_pkg::CLS_NORMAL;
            4'h1, 4'h2, 4'h3:    mode_class = timer16_pkg::CLS_PHASE;
            4'h4, 4'hc:          mode_class = timer16_pkg::CLS_CTC;
            4'h5, 4'h6, 4'h7,
            4'he, 4'hf:          mode_class = timer16_pkg::CLS_FAST;
            4'h8, 4'h9:          mode_class = timer16_pkg::CLS_PHASE_FREQ;
            4'ha, 4'hb:          mode_class = timer16_pkg::CLS_PHASE;
            4'hd:                mode_class = timer16_pkg::CLS_RESERVED;
            default:             mode_class = timer16_pkg::CLS_NORMAL;
        endcase
    end

    // TOP source per mode
    always_comb begin
        case (waveform_mode_select)
            4'h1, 4'h5:             top_value = timer16_pkg::TOP_8BIT;
            4'h2, 4'h6:             top_value = timer16_pkg::TOP_9BIT;
            4'h3, 4'h7:             top_value = timer16_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top_value = compare_value_a;
            4'h8, 4'ha, 4'hc, 4'he: top_value = capture_value_r;
            default:                top_value = timer16_pkg::CNT_MAX;
        endcase
    end

    assign tick      = timer_tick_i;
    assign at_top    = (cnt_r.value == top_value);
    assign at_bottom = (cnt_r.value == timer16_pkg::CNT_BOTTOM);
    assign at_max    = (cnt_r.value == timer16_pkg::CNT_MAX);
    assign match_a   = tick && !block_r && (cnt_r.value == compare_value_a);
    assign match_b   = tick && !block_r && (cnt_r.value == compare_value_b);

    // Buffered compare loads and overflow points
    assign immediate = (mode_class == timer16_pkg::CLS_NORMAL) ||
                       (mode_class == timer16_pkg::CLS_CTC) ||
                       (mode_class == timer16_pkg::CLS_RESERVED);
    assign load_at_top    = (mode_class == timer16_pkg::CLS_FAST) ||
                            (mode_class == timer16_pkg::CLS_PHASE);
    assign load_at_bottom = (mode_class == timer16_pkg::CLS_PHASE_FREQ);
    assign load_cmp = tick && ((load_at_top && at_top) ||
                               (load_at_bottom && at_bottom));

    always_comb begin
        case (mode_class)
            timer16_pkg::CLS_FAST:       ovf_event = at_top;
            timer16_pkg::CLS_PHASE,
            timer16_pkg::CLS_PHASE_FREQ: ovf_event = at_bottom && cnt_r.down;
            default:                     ovf_event = at_max;
        endcase
    end

    assign wr_cmp_a = reg_wr_i && (reg_addr_i == timer16_pkg::REG_CMP_A);
    assign wr_cmp_b = reg_wr_i && (reg_addr_i == timer16_pkg::REG_CMP_B);

    compare_slot u_slot_a (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .clk_en_i    (clk_en_i),
        .wr_i        (wr_cmp_a),
        .wdata_i     (reg_wdata_i),
        .immediate_i (immediate),
        .load_i      (load_cmp),
        .active_o    (compare_value_a),
        .buffer_o    (buffer_a)
    );

    compare_slot u_slot_b (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .clk_en_i    (clk_en_i),
        .wr_i        (wr_cmp_b),
        .wdata_i     (reg_wdata_i),
        .immediate_i (immediate),
        .load_i      (load_cmp),
        .active_o    (compare_value_b),
        .buffer_o    (buffer_b)
    );

    // Whether a channel output is connected at all
    function automatic logic connected(input logic [1:0] om, input logic pwm,
                                       input logic msb, input logic is_a);
        logic c;
        c = (om != timer16_pkg::OUT_OFF);
        if (pwm && om == timer16_pkg::OUT_TOGGLE) begin
            c = msb && is_a;
        end
        return c;
    endfunction

    // Next waveform level of one channel
    function automatic logic wave_next(input logic [1:0] om,
                                       input timer16_pkg::mode_class_e cls,
                                       input logic wave, input logic match,
                                       input logic top_hit, input logic down,
                                       input logic cmp_is_top, input logic conn);
        logic w;
        w = wave;
        if (conn) begin
            case (cls)
                timer16_pkg::CLS_FAST: begin
                    if (om == timer16_pkg::OUT_TOGGLE) begin
                        w = match ? !wave : wave;
                    end else if (top_hit) begin
                        w = (om == timer16_pkg::OUT_CLEAR);
                    end else if (match && !cmp_is_top) begin
                        w = (om == timer16_pkg::OUT_SET);
                    end
                end
                timer16_pkg::CLS_PHASE, timer16_pkg::CLS_PHASE_FREQ: begin
                    if (match) begin
                        if (om == timer16_pkg::OUT_TOGGLE) begin
                            w = !wave;
                        end else begin
                            w = (om == timer16_pkg::OUT_SET) ^ down;
                        end
                    end
                end
                default: begin
                    if (match) begin
                        case (om)
                            timer16_pkg::OUT_TOGGLE: w = !wave;
                            timer16_pkg::OUT_CLEAR:  w = 1'b0;
                            timer16_pkg::OUT_SET:    w = 1'b1;
                            default:                 w = wave;
                        endcase
                    end
                end
            endcase
        end
        return w;
    endfunction

    assign is_pwm = (mode_class == timer16_pkg::CLS_FAST) ||
                    (mode_class == timer16_pkg::CLS_PHASE) ||
                    (mode_class == timer16_pkg::CLS_PHASE_FREQ);
    assign conn_a = connected(chan_a_output_mode, is_pwm, waveform_mode_msb, 1'b1);
    assign conn_b = connected(chan_b_output_mode, is_pwm, waveform_mode_msb, 1'b0);

    // Register file next state
    always_comb begin
        timer_control_a_nxt = timer_control_a_r;
        timer_control_b_nxt = timer_control_b_r;
        timer_control_d_nxt = timer_control_d_r;
        capture_value_nxt   = capture_value_r;
        rdata_nxt           = timer16_pkg::WORD_RST;
        if (reg_wr_i) begin
            case (reg_addr_i)
                timer16_pkg::REG_CTRL_A:
                    timer_control_a_nxt = reg_wdata_i[7:0] & timer16_pkg::CTRL_A_WMASK;
                timer16_pkg::REG_CTRL_B:
                    timer_control_b_nxt = reg_wdata_i[7:0] & timer16_pkg::CTRL_B_WMASK;
                timer16_pkg::REG_CTRL_D:
                    timer_control_d_nxt = reg_wdata_i[7:0];
                timer16_pkg::REG_CAPTURE:
                    capture_value_nxt = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                timer16_pkg::REG_CTRL_A:  rdata_nxt = {8'h00, timer_control_a_r};
                timer16_pkg::REG_CTRL_B:  rdata_nxt = {8'h00, timer_control_b_r};
                timer16_pkg::REG_CTRL_D:  rdata_nxt = {8'h00, timer_control_d_r};
                timer16_pkg::REG_COUNTER: rdata_nxt = cnt_r.value;
                timer16_pkg::REG_CMP_A:   rdata_nxt = buffer_a;
                timer16_pkg::REG_CMP_B:   rdata_nxt = buffer_b;
                timer16_pkg::REG_CAPTURE: rdata_nxt = capture_value_r;
                timer16_pkg::REG_FLAGS:   rdata_nxt = {13'h0000, flags_r};
                default:                  rdata_nxt = timer16_pkg::WORD_RST;
            endcase
        end
    end

    // Counter sequence, flags and waveforms
    always_comb begin
        cnt_nxt   = cnt_r;
        flags_nxt = flags_r;
        block_nxt = block_r;
        wave_a_nxt = wave_a_r;
        wave_b_nxt = wave_b_r;
        if (tick) begin
            block_nxt = 1'b0;
            case (mode_class)
                timer16_pkg::CLS_CTC, timer16_pkg::CLS_FAST: begin
                    cnt_nxt.value = at_top ? timer16_pkg::CNT_BOTTOM
                                           : cnt_r.value + 16'h0001;
                    cnt_nxt.down  = 1'b0;
                end
                timer16_pkg::CLS_PHASE, timer16_pkg::CLS_PHASE_FREQ: begin
                    if (!cnt_r.down && at_top) begin
                        cnt_nxt.down  = 1'b1;
                        cnt_nxt.value = cnt_r.value - 16'h0001;
                    end else if (cnt_r.down && at_bottom) begin
                        cnt_nxt.down  = 1'b0;
                        cnt_nxt.value = cnt_r.value + 16'h0001;
                    end else begin
                        cnt_nxt.value = cnt_r.down ? cnt_r.value - 16'h0001
                                                   : cnt_r.value + 16'h0001;
                    end
                end
                default: begin
                    cnt_nxt.value = cnt_r.value + 16'h0001;
                    cnt_nxt.down  = 1'b0;
                end
            endcase
            wave_a_nxt = wave_next(chan_a_output_mode, mode_class, wave_a_r, match_a, at_top,
                                   cnt_r.down, compare_value_a == top_value, conn_a);
            wave_b_nxt = wave_next(chan_b_output_mode, mode_class, wave_b_r, match_b, at_top,
                                   cnt_r.down, compare_value_b == top_value, conn_b);
        end
        // Write-one clear; a same-cycle set wins
        if (reg_wr_i && reg_addr_i == timer16_pkg::REG_FLAGS) begin
            flags_nxt = flags_r & ~timer16_pkg::flags_s'(reg_wdata_i[2:0]);
        end
        flags_nxt.overflow = flags_nxt.overflow | (tick && ovf_event);
        flags_nxt.match_a  = flags_nxt.match_a | match_a;
        flags_nxt.match_b  = flags_nxt.match_b | match_b;
        // Counter write blocks the next match
        if (reg_wr_i && reg_addr_i == timer16_pkg::REG_COUNTER) begin
            cnt_nxt.value = reg_wdata_i;
            block_nxt     = 1'b1;
        end
    end

    // Pin multiplexing
    always_comb begin
        pin_oe_n_nxt = ~port_dir_i;
        for (int i = 0; i < timer16_pkg::PINS_PER_CHAN; i++) begin
            pin_data_nxt[i] = (conn_a && chan_a_pin_enable[i] && port_dir_i[i])
                              ? wave_a_r : port_data_i[i];
            pin_data_nxt[i + timer16_pkg::PINS_PER_CHAN] =
                (conn_b && chan_b_pin_enable[i] &&
                 port_dir_i[i + timer16_pkg::PINS_PER_CHAN])
                ? wave_b_r : port_data_i[i + timer16_pkg::PINS_PER_CHAN];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            timer_control_a_r <= timer16_pkg::CTRL_RST;
            timer_control_b_r <= timer16_pkg::CTRL_RST;
            timer_control_d_r <= timer16_pkg::CTRL_RST;
            capture_value_r   <= timer16_pkg::WORD_RST;
            cnt_r             <= '0;
            flags_r           <= '0;
            block_r           <= 1'b0;
            wave_a_r          <= 1'b0;
            wave_b_r          <= 1'b0;
            pin_data_r        <= 8'h00;
            pin_oe_n_r        <= 8'hff;
            rdata_r           <= timer16_pkg::WORD_RST;
        end else if (clk_en_i) begin
            timer_control_a_r <= timer_control_a_nxt;
            timer_control_b_r <= timer_control_b_nxt;
            timer_control_d_r <= timer_control_d_nxt;
            capture_value_r   <= capture_value_nxt;
            cnt_r             <= cnt_nxt;
            flags_r           <= flags_nxt;
            block_r           <= block_nxt;
            wave_a_r          <= wave_a_nxt;
            wave_b_r          <= wave_b_nxt;
            pin_data_r        <= pin_data_nxt;
            pin_oe_n_r        <= pin_oe_n_nxt;
            rdata_r           <= rdata_nxt;
        end
    end

    assign reg_rdata_o       = rdata_r;
    assign pin_data_o        = pin_data_r;
    assign pin_oe_n_o        = pin_oe_n_r;
    assign chan_a_wave_out_o = wave_a_r;
    assign chan_b_wave_out_o = wave_b_r;
    assign flags_o           = flags_r;

endmodule
`default_nettype wire

/* File: rtl/timer16_pkg.sv */
// Package for the 16-bit timer waveform and compare-output block.
// Assumes one system clock; the timer tick is a same-domain enable.
package timer16_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL_A  = 4'h0;
    localparam logic [3:0] REG_CTRL_B  = 4'h1;
    localparam logic [3:0] REG_CTRL_D  = 4'h2;
    localparam logic [3:0] REG_COUNTER = 4'h3;
    localparam logic [3:0] REG_CMP_A   = 4'h4;
    localparam logic [3:0] REG_CMP_B   = 4'h5;
    localparam logic [3:0] REG_CAPTURE = 4'h6;
    localparam logic [3:0] REG_FLAGS   = 4'h7;

    // Field positions
    localparam int CTRL_A_MODE_A_HI = 7;
    localparam int CTRL_A_MODE_A_LO = 6;
    localparam int CTRL_A_MODE_B_HI = 5;
    localparam int CTRL_A_MODE_B_LO = 4;
    localparam int CTRL_A_WLOW_HI   = 1;
    localparam int CTRL_A_WLOW_LO   = 0;
    localparam int CTRL_B_WHIGH_HI  = 4;
    localparam int CTRL_B_WHIGH_LO  = 3;
    localparam int FLAG_OVF         = 0;
    localparam int FLAG_MATCH_A     = 1;
    localparam int FLAG_MATCH_B     = 2;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    localparam logic [7:0] CTRL_B_WMASK = 8'h18;

    // Reset values
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    // Counter limits
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [15:0] TOP_8BIT   = 16'h00ff;
    localparam logic [15:0] TOP_9BIT   = 16'h01ff;
    localparam logic [15:0] TOP_10BIT  = 16'h03ff;

    // Output-mode field values
    localparam logic [1:0] OUT_OFF    = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR  = 2'h2;
    localparam logic [1:0] OUT_SET    = 2'h3;

    // Pins per channel
    localparam int PINS_PER_CHAN = 4;

    typedef enum logic [2:0] {
        CLS_NORMAL,
        CLS_CTC,
        CLS_FAST,
        CLS_PHASE,
        CLS_PHASE_FREQ,
        CLS_RESERVED
    } mode_class_e;

    typedef struct packed {
        logic match_b;
        logic match_a;
        logic overflow;
    } flags_s;

    typedef struct packed {
        logic [15:0] value;
        logic        down;
    } count_s;

endpackage

/* File: rtl/compare_slot.sv */
// One compare register: software buffer plus active compare value.
// Assumes the caller gives the load strobe already qualified by the tick.
`timescale 1ns/1ps
`default_nettype none
module compare_slot (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        immediate_i,
    input  wire logic        load_i,
    output logic      [15:0] active_o,
    output logic      [15:0] buffer_o
);

    logic [15:0] buffer_r;
    logic [15:0] buffer_nxt;
    logic [15:0] active_r;
    logic [15:0] active_nxt;

    // Buffer takes writes; active follows at once or on load
    always_comb begin
        buffer_nxt = buffer_r;
        active_nxt = active_r;
        if (wr_i) begin
            buffer_nxt = wdata_i;
        end
        if (wr_i && immediate_i) begin
            active_nxt = wdata_i;
        end else if (load_i || immediate_i) begin
            active_nxt = buffer_r;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            buffer_r <= timer16_pkg::WORD_RST;
            active_r <= timer16_pkg::WORD_RST;
        end else if (clk_en_i) begin
            buffer_r <= buffer_nxt;
            active_r <= active_nxt;
        end
    end

    assign active_o = active_r;
    assign buffer_o = buffer_r;

endmodule
`default_nettype wire

/* File: verification/timer16_wave_ctrl_assertions.sv */
// Checker for the timer waveform block, bound to its top module.
// Assumes one clock domain and the package compiled first.
`timescale 1ns/1ps
`default_nettype none
module timer16_wave_ctrl_checker (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        clk_en_i,
    input wire logic        timer_tick_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [7:0]  port_dir_i,
    input wire logic [7:0]  port_data_i,
    input wire logic [7:0]  pin_data_o,
    input wire logic [7:0]  pin_oe_n_o,
    input wire logic        chan_a_wave_out_o,
    input wire logic [2:0]  flags_o
);
    logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_d_r, ctrl_d_nxt;
    logic       ok_r, ok_nxt;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Shadow copies of control A and D
    always_comb begin
        ok_nxt = clk_en_i;
        ctrl_a_nxt = ctrl_a_r;
        ctrl_d_nxt = ctrl_d_r;
        if (clk_en_i && reg_wr_i && reg_addr_i == timer16_pkg::REG_CTRL_A) begin
            ctrl_a_nxt = reg_wdata_i[7:0] & timer16_pkg::CTRL_A_WMASK;
        end
        if (clk_en_i && reg_wr_i && reg_addr_i == timer16_pkg::REG_CTRL_D) begin
            ctrl_d_nxt = reg_wdata_i[7:0];
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ok_r <= 1'b0;
            ctrl_a_r <= 8'h00;
            ctrl_d_r <= 8'h00;
        end else begin
            ok_r <= ok_nxt;
            ctrl_a_r <= ctrl_a_nxt;
            ctrl_d_r <= ctrl_d_nxt;
        end
    end
    a_oe_from_dir: assert property (ok_r |-> pin_oe_n_o == ~$past(port_dir_i))
        else $error("pin enable not from direction");
    a_ctrl_a_read: assert property (ok_r && $past(reg_rd_i) && $past(reg_addr_i) == 4'h0
        |-> reg_rdata_o == {8'h00, $past(ctrl_a_r)}) else $error("control A read wrong");
    a_port_when_off: assert property (ok_r |-> ((pin_data_o ^ $past(port_data_i))
        & ~($past(port_dir_i) & $past(ctrl_d_r))) == 8'h00) else $error("gated pin not port");
    a_chan_a_drive: assert property (ok_r && $past(ctrl_a_r[7]) |-> ((pin_data_o[3:0]
        ^ {4{$past(chan_a_wave_out_o)}}) & $past(port_dir_i[3:0]) & $past(ctrl_d_r[3:0]))
        == 4'h0) else $error("channel A pin not wave");
    a_b_port_off: assert property (ok_r && $past(ctrl_a_r[5:4]) == 2'b00
        |-> pin_data_o[7:4] == $past(port_data_i[7:4])) else $error("channel B pin not port");
    a_flag_on_tick: assert property (ok_r && (flags_o & ~$past(flags_o)) != 3'b000
        |-> $past(timer_tick_i)) else $error("flag rose without tick");
    a_wave_on_tick: assert property (ok_r && $changed(chan_a_wave_out_o)
        |-> $past(timer_tick_i)) else $error("wave moved without tick");
    a_flag_sticky: assert property (ok_r && !($past(reg_wr_i) && $past(reg_addr_i) == 4'h7)
        |-> (flags_o & $past(flags_o)) == $past(flags_o)) else $error("flag dropped");
endmodule
bind timer16_wave_ctrl timer16_wave_ctrl_checker i_checker (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .clk_en_i(clk_en_i), .timer_tick_i(timer_tick_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .port_dir_i(port_dir_i), .port_data_i(port_data_i),
    .pin_data_o(pin_data_o), .pin_oe_n_o(pin_oe_n_o), .chan_a_wave_out_o(chan_a_wave_out_o),
    .flags_o(flags_o));
`default_nettype wire

/* File: verification/timer16_wave_ctrl_tb_top.sv */
// Bench for the timer waveform block: register calls and tick bursts.
// Assumes the design, package and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module timer16_wave_ctrl_tb_top;
    logic        clk = 1'b0, rst = 1'b1, tick = 1'b0, wr = 1'b0, rd = 1'b0, wave_a, wave_b;
    logic        en = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0]  dir = 8'hff, pdata = 8'h5a, pin, oe_n;
    logic [2:0]  flags;
    int          error_cnt = 0, compares = 0;
    timer16_wave_ctrl i_dut (.clk_sys_i(clk), .rst_i(rst), .clk_en_i(en), .timer_tick_i(tick),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .port_dir_i(dir), .port_data_i(pdata), .pin_data_o(pin), .pin_oe_n_o(oe_n),
        .chan_a_wave_out_o(wave_a), .chan_b_wave_out_o(wave_b), .flags_o(flags));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
        end
        @(posedge clk);
        tick <= 1'b0;
        #1;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(4'h0, 16'h0000);
        wr_reg(4'h0, 16'hffff);
        rd_chk(4'h0, 16'h00f3);
        wr_reg(4'h1, 16'hffff);
        rd_chk(4'h1, 16'h0018);
        wr_reg(4'h2, 16'hffff);
        rd_chk(4'h2, 16'h00ff);
        rd_chk(4'h8, 16'h0000);
        wr_reg(4'h1, 16'h0000);
        $display("test registers done");
        wr_reg(4'h4, 16'h0002);
        for (int m = 1; m < 4; m++) begin
            wr_reg(4'h0, 16'(m << 6));
            wr_reg(4'h1, 16'((m & 1) << 3));
            wr_reg(4'h3, 16'h0000);
            wr_reg(4'h7, 16'h0007);
            ticks(3);
            chk({15'h0, wave_a}, 16'(m != 2));
            chk({13'h0, flags}, 16'h0002);
        end
        $display("test match modes done");
        wr_reg(4'h0, 16'h00e1);
        wr_reg(4'h1, 16'h0008);
        wr_reg(4'h3, 16'h00fe);
        wr_reg(4'h7, 16'h0007);
        ticks(2);
        chk({12'h0, wave_b, flags, wave_a}, 16'h0012);
        ticks(3);
        chk({12'h0, wave_b, flags, wave_a}, 16'h000f);
        $display("test fast pwm done");
        @(posedge clk) dir <= 8'h3c;
        wr_reg(4'h2, 16'h0055);
        wr_reg(4'h0, 16'h0001);
        wr_reg(4'h1, 16'h0000);
        wr_reg(4'h3, 16'h0000);
        wr_reg(4'h7, 16'h0007);
        ticks(300);
        chk({15'h0, flags[0]}, 16'h0000);
        @(posedge clk) en <= 1'b0;
        ticks(20);
        @(posedge clk) en <= 1'b1;
        rd_chk(4'h3, 16'h00d2);
        ticks(250);
        chk({15'h0, flags[0]}, 16'h0001);
        $display("test phase correct done");
        tally_and_finish();
    end
    initial begin
        #50000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
